/* File: logic/dpio_regs.vh */
// Purpose: constants for the dual port parallel i/o adapter
// Assumes: 8-bit processor bus, two register-select lines
// Notes:   control register bit positions shared by both sections
`ifndef DPIO_REGS_VH
`define DPIO_REGS_VH
`define DPIO_SEL_PORT_A     2'h0
`define DPIO_SEL_CTRL_A     2'h1
`define DPIO_SEL_PORT_B     2'h2
`define DPIO_SEL_CTRL_B     2'h3
`define DPIO_CR_EN_FIRST    0
`define DPIO_CR_EDGE_FIRST  1
`define DPIO_CR_PORT_SEL    2
`define DPIO_CR_EN_SECOND   3
`define DPIO_CR_EDGE_SECOND 4
`define DPIO_CR_FLAG_SECOND 6
`define DPIO_CR_FLAG_FIRST  7
`define DPIO_CR_WR_MASK     8'h3f
`define DPIO_BYTE_ZERO      8'h00
`endif

/* File: logic/dpio_adapter.v */
// Purpose: two 8-bit parallel i/o sections with per-line direction and edge interrupt flags
// Assumes: sys_clk is the processor phase-two clock; control lines are asynchronous pins
// Notes:   control-line output/pulse/handshake modes are not built; second lines are inputs only
// Notes on behaviour
// - direction bit 0 makes the line input, 1 makes it a driven output
// - output lines drive the stored output-register bit level
// - control bit 2 picks output register (1) or direction register (0)
// - port A data read returns all eight line states
// - port A reads sensed pin level even for output lines
// - port B reads stored bits for outputs, pin level for inputs
// - input lines are never driven from the output register
// - port B input lines have their output enable released
// - control, direction and output writable; control and direction readable
// - one active-low open-drain request per section, fed only by that section
// - section A bit 7 sets on active first-input edge regardless of enable
// - section A bit 0 gates bit-7 flag onto the request
// - section A bit 6 sets on active second-line edge regardless of enable
// - section A bit 3 gates bit-6 flag onto the request
// - reading port A data clears section A flags 6 and 7
// - section B mirrors section A flag and enable behaviour
// - reading port B data clears section B flags 6 and 7
// - request low exactly when (flag7 and en0) or (flag6 and en3)
// - reset clears every register, making all lines inputs
// - select 00 port A, 01 control A, 10 port B, 11 control B
// - control bit 1 picks falling (0) or rising (1) first-input edge
`timescale 1ns/100ps
`include "dpio_regs.vh"
module dpio_adapter (
    input  wire       sys_clk,
    input  wire       rst,
    input  wire       select_high_first,
    input  wire       select_high_second,
    input  wire       select_low_third_n,
    input  wire       reg_select_high,
    input  wire       reg_select_low,
    input  wire       read_not_write,
    input  wire [7:0] data_in,
    output reg  [7:0] data_out,
    output reg        data_oe_n,
    input  wire [7:0] port_a_lines_in,
    output reg  [7:0] port_a_lines_out,
    output reg  [7:0] port_a_lines_oe_n,
    input  wire [7:0] port_b_lines_in,
    output reg  [7:0] port_b_lines_out,
    output reg  [7:0] port_b_lines_oe_n,
    input  wire       a_ctrl_in_first,
    input  wire       a_ctrl_line_second,
    input  wire       b_ctrl_in_first,
    input  wire       b_ctrl_line_second,
    output reg        section_a_irq_n_out,
    output reg        section_a_irq_n_oe_n,
    output reg        section_b_irq_n_out,
    output reg        section_b_irq_n_oe_n
);
    reg  [7:0] port_a_direction_r;
    reg  [7:0] port_b_direction_r;
    reg  [7:0] port_a_output_data_r;
    reg  [7:0] port_b_output_data_r;
    reg  [7:0] section_a_control_r;
    reg  [7:0] section_b_control_r;
    // three-stage samplers; stage 1 feeds stage 2 only
    reg  [7:0] pa_s1_r, pa_s2_r, pa_s3_r;
    reg  [7:0] pb_s1_r, pb_s2_r, pb_s3_r;
    reg  [7:0] pa_stable_r, pb_stable_r;
    reg  [3:0] cl_s1_r, cl_s2_r, cl_s3_r, cl_stable_r;
    reg  [7:0] rd_nxt;
    wire       sel;
    wire [1:0] rsel;
    wire       wr, rd;
    wire [3:0] cl_new;
    wire [3:0] cl_rise, cl_fall;
    wire       a_first_hit, a_second_hit, b_first_hit, b_second_hit;
    wire       a_clr, b_clr;
    wire       a_irq, b_irq;

    assign sel  = select_high_first & select_high_second & ~select_low_third_n;
    assign rsel = {reg_select_high, reg_select_low};
    assign wr   = sel & ~read_not_write;
    assign rd   = sel & read_not_write;
    // a change counts once stages 2 and 3 agree
    assign cl_new  = (cl_s2_r & cl_s3_r) | (~(cl_s2_r ^ cl_s3_r) & 4'h0) | ((cl_s2_r ^ cl_s3_r) & cl_stable_r);
    assign cl_rise = cl_new & ~cl_stable_r;
    assign cl_fall = ~cl_new & cl_stable_r;
    // edge polarity: bit 1 for first input, bit 4 for second line
    assign a_first_hit  = section_a_control_r[`DPIO_CR_EDGE_FIRST]  ? cl_rise[0] : cl_fall[0];
    assign a_second_hit = section_a_control_r[`DPIO_CR_EDGE_SECOND] ? cl_rise[1] : cl_fall[1];
    assign b_first_hit  = section_b_control_r[`DPIO_CR_EDGE_FIRST]  ? cl_rise[2] : cl_fall[2];
    assign b_second_hit = section_b_control_r[`DPIO_CR_EDGE_SECOND] ? cl_rise[3] : cl_fall[3];
    assign a_clr = rd & (rsel == `DPIO_SEL_PORT_A) & section_a_control_r[`DPIO_CR_PORT_SEL];
    assign b_clr = rd & (rsel == `DPIO_SEL_PORT_B) & section_b_control_r[`DPIO_CR_PORT_SEL];
    assign a_irq = (section_a_control_r[`DPIO_CR_FLAG_FIRST] & section_a_control_r[`DPIO_CR_EN_FIRST]) |
                   (section_a_control_r[`DPIO_CR_FLAG_SECOND] & section_a_control_r[`DPIO_CR_EN_SECOND]);
    assign b_irq = (section_b_control_r[`DPIO_CR_FLAG_FIRST] & section_b_control_r[`DPIO_CR_EN_FIRST]) |
                   (section_b_control_r[`DPIO_CR_FLAG_SECOND] & section_b_control_r[`DPIO_CR_EN_SECOND]);

    // read mux
    always @* begin
        rd_nxt = `DPIO_BYTE_ZERO;
        case (rsel)
            `DPIO_SEL_PORT_A: begin
                if (section_a_control_r[`DPIO_CR_PORT_SEL]) begin
                    rd_nxt = pa_stable_r;
                end else begin
                    rd_nxt = port_a_direction_r;
                end
            end
            `DPIO_SEL_CTRL_A: begin
                rd_nxt = section_a_control_r;
            end
            `DPIO_SEL_PORT_B: begin
                if (section_b_control_r[`DPIO_CR_PORT_SEL]) begin
                    rd_nxt = (port_b_output_data_r & port_b_direction_r) |
                             (pb_stable_r & ~port_b_direction_r);
                end else begin
                    rd_nxt = port_b_direction_r;
                end
            end
            `DPIO_SEL_CTRL_B: begin
                rd_nxt = section_b_control_r;
            end
            default: begin
                rd_nxt = `DPIO_BYTE_ZERO;
            end
        endcase
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            pa_s1_r <= `DPIO_BYTE_ZERO; pa_s2_r <= `DPIO_BYTE_ZERO; pa_s3_r <= `DPIO_BYTE_ZERO;
            pb_s1_r <= `DPIO_BYTE_ZERO; pb_s2_r <= `DPIO_BYTE_ZERO; pb_s3_r <= `DPIO_BYTE_ZERO;
            pa_stable_r <= `DPIO_BYTE_ZERO;
            pb_stable_r <= `DPIO_BYTE_ZERO;
            cl_s1_r <= 4'h0; cl_s2_r <= 4'h0; cl_s3_r <= 4'h0; cl_stable_r <= 4'h0;
        end else begin
            pa_s1_r <= port_a_lines_in; pa_s2_r <= pa_s1_r; pa_s3_r <= pa_s2_r;
            pb_s1_r <= port_b_lines_in; pb_s2_r <= pb_s1_r; pb_s3_r <= pb_s2_r;
            pa_stable_r <= (pa_s2_r & pa_s3_r) | ((pa_s2_r ^ pa_s3_r) & pa_stable_r);
            pb_stable_r <= (pb_s2_r & pb_s3_r) | ((pb_s2_r ^ pb_s3_r) & pb_stable_r);
            cl_s1_r <= {b_ctrl_line_second, b_ctrl_in_first, a_ctrl_line_second, a_ctrl_in_first};
            cl_s2_r <= cl_s1_r;
            cl_s3_r <= cl_s2_r;
            cl_stable_r <= cl_new;
        end
    end

    // registers and flags; a flag set in the clearing cycle wins
    always @(posedge sys_clk) begin
        if (rst) begin
            port_a_direction_r   <= `DPIO_BYTE_ZERO;
            port_b_direction_r   <= `DPIO_BYTE_ZERO;
            port_a_output_data_r <= `DPIO_BYTE_ZERO;
            port_b_output_data_r <= `DPIO_BYTE_ZERO;
            section_a_control_r  <= `DPIO_BYTE_ZERO;
            section_b_control_r  <= `DPIO_BYTE_ZERO;
        end else begin
            if (wr) begin
                case (rsel)
                    `DPIO_SEL_PORT_A: begin
                        if (section_a_control_r[`DPIO_CR_PORT_SEL]) begin
                            port_a_output_data_r <= data_in;
                        end else begin
                            port_a_direction_r <= data_in;
                        end
                    end
                    `DPIO_SEL_PORT_B: begin
                        if (section_b_control_r[`DPIO_CR_PORT_SEL]) begin
                            port_b_output_data_r <= data_in;
                        end else begin
                            port_b_direction_r <= data_in;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            // flags are read-only from the bus side
            section_a_control_r[5:0] <= (wr && rsel == `DPIO_SEL_CTRL_A) ?
                data_in[5:0] : section_a_control_r[5:0];
            section_b_control_r[5:0] <= (wr && rsel == `DPIO_SEL_CTRL_B) ?
                data_in[5:0] : section_b_control_r[5:0];
            section_a_control_r[`DPIO_CR_FLAG_FIRST] <= a_first_hit |
                (section_a_control_r[`DPIO_CR_FLAG_FIRST] & ~a_clr);
            section_a_control_r[`DPIO_CR_FLAG_SECOND] <= a_second_hit |
                (section_a_control_r[`DPIO_CR_FLAG_SECOND] & ~a_clr);
            section_b_control_r[`DPIO_CR_FLAG_FIRST] <= b_first_hit |
                (section_b_control_r[`DPIO_CR_FLAG_FIRST] & ~b_clr);
            section_b_control_r[`DPIO_CR_FLAG_SECOND] <= b_second_hit |
                (section_b_control_r[`DPIO_CR_FLAG_SECOND] & ~b_clr);
        end
    end

    // registered pin and bus outputs
    always @(posedge sys_clk) begin
        if (rst) begin
            data_out             <= `DPIO_BYTE_ZERO;
            data_oe_n            <= 1'b1;
            port_a_lines_out     <= `DPIO_BYTE_ZERO;
            port_a_lines_oe_n    <= 8'hff;
            port_b_lines_out     <= `DPIO_BYTE_ZERO;
            port_b_lines_oe_n    <= 8'hff;
            section_a_irq_n_out  <= 1'b0;
            section_a_irq_n_oe_n <= 1'b1;
            section_b_irq_n_out  <= 1'b0;
            section_b_irq_n_oe_n <= 1'b1;
        end else begin
            data_out             <= rd_nxt;
            data_oe_n            <= ~rd;
            port_a_lines_out     <= port_a_output_data_r;
            port_a_lines_oe_n    <= ~port_a_direction_r;
            port_b_lines_out     <= port_b_output_data_r;
            port_b_lines_oe_n    <= ~port_b_direction_r;
            section_a_irq_n_out  <= 1'b0;
            section_a_irq_n_oe_n <= ~a_irq;
            section_b_irq_n_out  <= 1'b0;
            section_b_irq_n_oe_n <= ~b_irq;
        end
    end
endmodule

/* File: tb/dpio_periph.sv */
// Purpose: peripheral devices on both ports
// Assumes: ext values are driven on every line the adapter leaves undriven
// Notes:   load_mask holds chosen driven lines low, as a heavy load would
`timescale 1ns/100ps
module dpio_periph (
    input  wire [7:0] a_out,
    input  wire [7:0] a_oe_n,
    input  wire [7:0] b_out,
    input  wire [7:0] b_oe_n,
    input  wire [7:0] ext_a,
    input  wire [7:0] ext_b,
    input  wire [7:0] load_mask,
    output wire [7:0] a_pin,
    output wire [7:0] b_pin
);
    assign a_pin = (~a_oe_n & a_out & ~load_mask) | (a_oe_n & ext_a);
    assign b_pin = (~b_oe_n & b_out & ~load_mask) | (b_oe_n & ext_b);
endmodule

/* File: tb/dpio_props.sv */
// Purpose: port checks for the dual port i/o adapter
// Assumes: one clock, synchronous reset
// Notes:   pins lag a register write by two edges
`timescale 1ns/100ps
module dpio_props (
    input wire       sys_clk,
    input wire       rst,
    input wire       select_high_first,
    input wire       select_high_second,
    input wire       select_low_third_n,
    input wire       reg_select_high,
    input wire       reg_select_low,
    input wire       read_not_write,
    input wire [7:0] data_in,
    input wire       data_oe_n,
    input wire [7:0] port_a_lines_out,
    input wire [7:0] port_a_lines_oe_n,
    input wire [7:0] port_b_lines_out,
    input wire [7:0] port_b_lines_oe_n,
    input wire       section_a_irq_n_out,
    input wire       section_a_irq_n_oe_n,
    input wire       section_b_irq_n_out,
    input wire       section_b_irq_n_oe_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire       sel = select_high_first & select_high_second & ~select_low_third_n;
    wire [1:0] rs  = {reg_select_high, reg_select_low};
    wire       wr  = sel & ~read_not_write;
    chk_reset_all_inputs: assert property ($fell(rst) |-> &port_a_lines_oe_n && &port_b_lines_oe_n)
        else $error("lines driven after reset");
    chk_irq_open_drain: assert property (!section_a_irq_n_out && !section_b_irq_n_out)
        else $error("request pin driven high");
    chk_read_drives_bus: assert property (sel && read_not_write |=> !data_oe_n)
        else $error("read not driven");
    chk_idle_bus_free: assert property (!sel |=> data_oe_n)
        else $error("bus driven while unselected");
    chk_a_irq_masked: assert property (wr && rs == 2'h1 && !data_in[0] && !data_in[3] |=> ##1 section_a_irq_n_oe_n)
        else $error("section a request while disabled");
    chk_b_irq_masked: assert property (wr && rs == 2'h3 && !data_in[0] && !data_in[3] |=> ##1 section_b_irq_n_oe_n)
        else $error("section b request while disabled");
    chk_a_pins_cause: assert property ($changed({port_a_lines_out, port_a_lines_oe_n}) && !$past(rst) && !$past(rst, 2)
        |-> $past(wr, 2) && $past(rs, 2) == 2'h0)
        else $error("port a pins moved without write");
    chk_b_pins_cause: assert property ($changed({port_b_lines_out, port_b_lines_oe_n}) && !$past(rst) && !$past(rst, 2)
        |-> $past(wr, 2) && $past(rs, 2) == 2'h2)
        else $error("port b pins moved without write");
    cov_irq_a: cover property (!section_a_irq_n_oe_n);
    cov_irq_b: cover property (!section_b_irq_n_oe_n);
    cov_read: cover property (sel && read_not_write && rs == 2'h2);
endmodule
bind dpio_adapter dpio_props u_props (.*);

/* File: tb/dpio_adapter_tb_top.sv */
// Purpose: register and flag tests of the dual port i/o adapter
// Assumes: a selected access is held for one edge
// Notes:   bit 0 of each port is loaded so pin and register reads differ
`timescale 1ns/100ps
module dpio_adapter_tb_top;
    reg        sys_clk = 1'b0;
    reg        rst = 1'b1;
    reg        cs_on = 1'b0;
    reg  [1:0] rs = 2'h0;
    reg        rnw = 1'b1;
    reg  [7:0] din = 8'h00;
    reg  [3:0] ctl = 4'h0;
    reg  [7:0] v;
    wire [7:0] dout, pa_o, pa_e, pb_o, pb_e, pa, pb;
    wire       doe_n, ia_o, ia_e, ib_o, ib_e;
    integer    fails = 0;
    integer    n_compared = 0;
    integer    i;
    dpio_adapter u_dut (.sys_clk(sys_clk), .rst(rst), .select_high_first(cs_on), .select_high_second(cs_on),
        .select_low_third_n(~cs_on), .reg_select_high(rs[1]), .reg_select_low(rs[0]), .read_not_write(rnw),
        .data_in(din), .data_out(dout), .data_oe_n(doe_n), .port_a_lines_in(pa), .port_a_lines_out(pa_o),
        .port_a_lines_oe_n(pa_e), .port_b_lines_in(pb), .port_b_lines_out(pb_o), .port_b_lines_oe_n(pb_e),
        .a_ctrl_in_first(ctl[0]), .a_ctrl_line_second(ctl[1]), .b_ctrl_in_first(ctl[2]),
        .b_ctrl_line_second(ctl[3]), .section_a_irq_n_out(ia_o), .section_a_irq_n_oe_n(ia_e),
        .section_b_irq_n_out(ib_o), .section_b_irq_n_oe_n(ib_e));
    dpio_periph u_periph (.a_out(pa_o), .a_oe_n(pa_e), .b_out(pb_o), .b_oe_n(pb_e), .ext_a(8'h3c),
        .ext_b(8'h3c), .load_mask(8'h01), .a_pin(pa), .b_pin(pb));
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    task chk(input [8*8-1:0] what, input [7:0] seen, input [7:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("FAIL %0s expected %h seen %h", what, exp, seen);
        end
    endtask
    task acc(input [1:0] a, input w, input [7:0] d);
        @(posedge sys_clk);
        #1 {cs_on, rs, rnw, din} = {1'b1, a, ~w, d};
        @(posedge sys_clk);
        #1 cs_on = 1'b0;
        v = dout;
    endtask
    task rd(input [1:0] a, input [7:0] exp, input [8*8-1:0] what);
        acc(a, 1'b0, 8'h00);
        chk(what, v, exp);
    endtask
    task irq_case(input s, input [7:0] c, input ln, input rise, input [7:0] fl, input irq);
        acc({s, 1'b1}, 1'b1, c);
        ctl[{s, ln}] = ~rise;
        repeat (6) @(posedge sys_clk);
        acc({s, 1'b0}, 1'b0, 8'h00);
        ctl[{s, ln}] = rise;
        repeat (6) @(posedge sys_clk);
        #1 chk("irq", {7'h0, s ? ib_e : ia_e}, {7'h0, ~irq});
        chk("irq othr", {7'h0, s ? ia_e : ib_e}, 8'h01);
        rd({s, 1'b1}, c | fl, "flags");
        acc({s, 1'b0}, 1'b0, 8'h00);
        rd({s, 1'b1}, c, "flag clr");
    endtask
    task stop_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge sys_clk);
        fails = fails + 1;
        stop_test;
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        #1 rst = 1'b0;
        rd(2'h1, 8'h00, "ctrl a");
        rd(2'h3, 8'h00, "ctrl b");
        rd(2'h0, 8'h00, "dir a");
        for (i = 0; i < 2; i = i + 1) begin
            acc({i[0], 1'b0}, 1'b1, 8'h0f);
            rd({i[0], 1'b0}, 8'h0f, "dir rb");
            acc({i[0], 1'b1}, 1'b1, 8'hc4);
            rd({i[0], 1'b1}, 8'h04, "ctrl rb");
            acc({i[0], 1'b0}, 1'b1, 8'ha5);
        end
        repeat (6) @(posedge sys_clk);
        #1 chk("oe a", pa_e, 8'hf0);
        chk("oe b", pb_e, 8'hf0);
        chk("drive a", pa_o & ~pa_e, 8'h05);
        rd(2'h0, 8'h34, "port a");
        rd(2'h2, 8'h35, "port b");
        $display("port tests done");
        irq_case(1'b0, 8'h05, 1'b0, 1'b0, 8'h80, 1'b1);
        irq_case(1'b0, 8'h06, 1'b0, 1'b1, 8'h80, 1'b0);
        irq_case(1'b0, 8'h1c, 1'b1, 1'b1, 8'h40, 1'b1);
        irq_case(1'b0, 8'h04, 1'b1, 1'b0, 8'h40, 1'b0);
        irq_case(1'b1, 8'h07, 1'b0, 1'b1, 8'h80, 1'b1);
        irq_case(1'b1, 8'h0c, 1'b1, 1'b0, 8'h40, 1'b1);
        $display("flag tests done");
        stop_test;
    end
endmodule
